/* File: hdl/sshp_defs.svh */
`ifndef SSHP_DEFS_SVH
`define SSHP_DEFS_SVH

// ****************************************
// register offsets
// ****************************************
`define SSHP_OFF_CTRL 12'h000
`define SSHP_OFF_STATUS 12'h004
`define SSHP_OFF_COUNT 12'h008
`define SSHP_OFF_LADDR 12'h00c

// ****************************************
// field positions and reset values
// ****************************************
`define SSHP_CTRL_HOLD_BIT 0
`define SSHP_ST_BIG_BIT 0
`define SSHP_ST_SPLIT_BIT 1
`define SSHP_ST_CFGOK_BIT 2
`define SSHP_ST_PEND_BIT 3
`define SSHP_ST_DIR_BIT 4
`define SSHP_ST_CFG_LSB 8
`define SSHP_CTRL_RESET 1'h0

// ****************************************
// strap codes and timing counts
// ****************************************
`define SSHP_CFG_ENDIAN_BIT 4
`define SSHP_CFG_SPLIT_CODE 4'hf
`define SSHP_CFG_SETTLE 2'h2
`define SSHP_MEM_AW 8

`endif

/* File: hdl/sshp_pkg.sv */
package sshp_pkg;

    // ****************************************
    // host-side transfer states
    // ****************************************
    typedef enum logic [2:0] {
        HS_IDLE = 3'b001,
        HS_REQ = 3'b010,
        HS_DONE = 3'b100
    } sshp_hstate_t;

    typedef logic [16:0] sshp_addr_t;
    typedef logic [15:0] sshp_word_t;

endpackage

/* File: hdl/sshp_host_port.sv */
`timescale 1ns/1ps
`include "sshp_defs.svh"
// Functional notes
// R1 - host transfers are timed by the separate host bus clock, not the core clock.
// R2 - the port is 16 bits wide with a 17-bit address and 16-bit data bus.
// R3 - the high byte enable qualifies the upper byte for reads and writes; the code gates writes only, reads return both bytes.
// R4 - the host drives the write strobe low while writing; it enables the low byte.
// R5 - the host drives the read strobe low while reading; the port then drives data.
// R6 - hold-off tells the host when read data is valid or write data was taken.
// R7 - on contention with refresh, hold-off stays asserted until arbitration grants.
// R8 - hold-off is active low.
// R9 - the host decodes its upper address lines into the select input.
// R10 - bus phase strobe and direction are ignored during transfers and tied high.
// R11 - host strobes are asynchronous to the host bus clock and are synchronised.
// R12 - the four straps and the bus phase strobe are caught at reset release.
// R13 - endian strap 0 gives little-endian order, 1 gives big-endian order.
// R14 - split-strobe mode needs all three bus straps and the bus phase strobe at 1.
// R15 - hold-off asserts once a selected strobe is seen, releases when data is stable.
// R16 - read, write and select pass two host-clock flip-flops before use.
module sshp_host_port (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic core_clock_in,
    input wire logic host_bus_clock,
    input wire sshp_pkg::sshp_addr_t host_addr,
    input wire sshp_pkg::sshp_word_t host_data_in,
    output sshp_pkg::sshp_word_t host_data_out,
    output logic host_data_oe,
    input wire logic device_select_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic high_byte_enable_n,
    input wire logic bus_phase_strobe_n,
    input wire logic direction_n,
    input wire logic endian_cfg,
    input wire logic [2:0] bus_sel_cfg,
    output logic hold_off_n
);
    import sshp_pkg::*;

    // ****************************************
    // state records
    // ****************************************
    typedef struct packed {
        logic [2:0] strb_s1;
        logic [2:0] strb_s2;
        logic split_s1;
        logic split_s2;
        logic ack_s1;
        logic ack_s2;
        logic ack_s3;
        sshp_addr_t addr_s1;
        sshp_addr_t addr_s2;
        sshp_word_t data_s1;
        sshp_word_t data_s2;
        logic hbe_s1;
        logic hbe_s2;
        sshp_hstate_t state;
        logic req_tgl;
        logic wr_op;
        logic hbe;
        sshp_addr_t addr;
        sshp_word_t wdata;
        sshp_word_t rdata;
        logic hold_n;
        logic oe;
    } sshp_host_t;

    typedef struct packed {
        logic [4:0] cfg_s1;
        logic [4:0] cfg_s2;
        logic [1:0] cfg_cnt;
        logic [4:0] cfg_val;
        logic cfg_valid;
        logic dir_s1;
        logic dir_s2;
        logic req_s1;
        logic req_s2;
        logic req_s3;
        logic pending;
        logic ack_tgl;
        sshp_word_t rdata;
        logic refresh_hold;
        logic [15:0] acc_cnt;
        sshp_addr_t last_addr;
        logic [31:0] prdata;
    } sshp_core_t;

    sshp_host_t h_reg;
    sshp_host_t h_next;
    sshp_core_t c_reg;
    sshp_core_t c_next;
    logic [1:0] hrst_reg;
    logic hrst_n;
    sshp_word_t mem [0:(1 << `SSHP_MEM_AW)-1];
    logic mem_we;
    logic [`SSHP_MEM_AW-1:0] mem_idx;
    sshp_word_t mem_wdata;
    logic split_mode;
    logic big_end;
    logic h_go;
    logic h_busy;
    logic apb_setup;
    logic apb_access;
    logic addr_ok;

    function automatic sshp_word_t swap16(input sshp_word_t w);
        swap16 = {w[7:0], w[15:8]};
    endfunction

    function automatic logic reg_hit(input logic [11:0] a);
        reg_hit = (a == `SSHP_OFF_CTRL) || (a == `SSHP_OFF_STATUS) ||
                  (a == `SSHP_OFF_COUNT) || (a == `SSHP_OFF_LADDR);
    endfunction

    // ****************************************
    // host bus clock domain
    // ****************************************
    always_ff @(posedge host_bus_clock or negedge presetn) begin
        if (!presetn) begin
            hrst_reg <= 2'h0;
        end else begin
            hrst_reg <= {hrst_reg[0], 1'b1};
        end
    end
    assign hrst_n = hrst_reg[1];

    always_comb begin
        h_next = h_reg;
        h_next.strb_s1 = {device_select_n, read_strobe_n, write_strobe_n}; // R11
        h_next.strb_s2 = h_reg.strb_s1; // R16
        h_next.split_s1 = split_mode;
        h_next.split_s2 = h_reg.split_s1;
        h_next.ack_s1 = c_reg.ack_tgl;
        h_next.ack_s2 = h_reg.ack_s1;
        h_next.ack_s3 = h_reg.ack_s2;
        h_next.addr_s1 = host_addr;
        h_next.addr_s2 = h_reg.addr_s1;
        h_next.data_s1 = host_data_in;
        h_next.data_s2 = h_reg.data_s1;
        h_next.hbe_s1 = high_byte_enable_n;
        h_next.hbe_s2 = h_reg.hbe_s1;
        unique case (h_reg.state)
            HS_IDLE: begin
                if (h_reg.split_s2 && h_go) begin // R14
                    h_next.state = HS_REQ;
                    h_next.req_tgl = ~h_reg.req_tgl;
                    h_next.wr_op = ~h_reg.strb_s2[0]; // R4
                    h_next.hbe = ~h_reg.hbe_s2; // R3
                    h_next.addr = h_reg.addr_s2; // R2
                    h_next.wdata = h_reg.data_s2;
                    h_next.hold_n = 1'b0; // R15
                    h_next.oe = h_reg.strb_s2[0]; // R5
                end
            end
            HS_REQ: begin
                if (h_reg.ack_s2 != h_reg.ack_s3) begin // R7
                    h_next.rdata = c_reg.rdata;
                    h_next.hold_n = 1'b1; // R6
                    h_next.state = HS_DONE;
                end
            end
            HS_DONE: begin
                if (!h_busy) begin
                    h_next.oe = 1'b0;
                    h_next.state = HS_IDLE;
                end
            end
        endcase
    end

    // bus phase strobe and direction play no part in a transfer
    assign h_go = !h_reg.strb_s2[2] && (!h_reg.strb_s2[1] || !h_reg.strb_s2[0]); // R10
    assign h_busy = h_go;

    always_ff @(posedge host_bus_clock or negedge hrst_n) begin // R1
        if (!hrst_n) begin
            h_reg <= '{strb_s1: 3'h7, strb_s2: 3'h7, state: HS_IDLE, hold_n: 1'b1,
                       default: '0};
        end else begin
            h_reg <= h_next;
        end
    end

    assign hold_off_n = h_reg.hold_n; // R8
    assign host_data_out = h_reg.rdata;
    assign host_data_oe = h_reg.oe;

    a_hold_on_strobe: assert property (@(posedge host_bus_clock) disable iff (!hrst_n) // R15
        (h_reg.state == HS_IDLE && h_reg.split_s2 && h_go) |=> !hold_off_n)
        else $error("hold-off not asserted after selected strobe");

    a_hold_until_grant: assert property (@(posedge host_bus_clock) disable iff (!hrst_n) // R7
        (!hold_off_n && h_reg.ack_s2 == h_reg.ack_s3) |=> !hold_off_n)
        else $error("hold-off released before grant");

    a_read_data_valid: assert property (@(posedge host_bus_clock) disable iff (!hrst_n) // R6
        ($rose(hold_off_n) && !h_reg.wr_op) |-> host_data_oe && host_data_out == c_reg.rdata
        ##1 (host_data_oe || h_reg.state == HS_IDLE))
        else $error("read data not driven at hold-off release");

    a_no_mode_no_hold: assert property (@(posedge host_bus_clock) disable iff (!hrst_n) // R14
        (!h_reg.split_s2 && h_reg.state == HS_IDLE) |=> hold_off_n)
        else $error("hold-off asserted outside split-strobe mode");

    a_sync_two_stage: assert property (@(posedge host_bus_clock) disable iff (!hrst_n) // R16
        (h_reg.state == HS_IDLE && &h_reg.strb_s2[1:0]) |=> h_reg.state == HS_IDLE)
        else $error("transfer started before strobe synchronised");

    a_oe_read_only: assert property (@(posedge host_bus_clock) disable iff (!hrst_n) // R5
        (h_reg.state != HS_IDLE && h_reg.wr_op) |-> !host_data_oe)
        else $error("data bus driven during a write");

    a_idle_no_hold: assert property (@(posedge host_bus_clock) disable iff (!hrst_n) // R6
        (h_reg.state == HS_IDLE) |-> hold_off_n)
        else $error("hold-off asserted while idle");

    // ****************************************
    // core domain: straps, arbitration, memory
    // ****************************************
    assign split_mode = c_reg.cfg_valid && (c_reg.cfg_val[3:0] == `SSHP_CFG_SPLIT_CODE); // R14
    assign big_end = c_reg.cfg_val[`SSHP_CFG_ENDIAN_BIT];
    assign mem_idx = h_reg.addr[`SSHP_MEM_AW:1];

    always_comb begin
        logic lo_bus;
        logic hi_bus;
        sshp_word_t wd;
        sshp_word_t cur;
        lo_bus = 1'b1;
        hi_bus = h_reg.hbe;
        wd = big_end ? swap16(h_reg.wdata) : h_reg.wdata; // R13
        cur = mem[mem_idx];
        mem_wdata = cur;
        if (big_end ? hi_bus : lo_bus) begin // R4
            mem_wdata[7:0] = wd[7:0];
        end
        if (big_end ? lo_bus : hi_bus) begin // R3
            mem_wdata[15:8] = wd[15:8];
        end
        c_next = c_reg;
        mem_we = 1'b0;
        c_next.cfg_s1 = {endian_cfg, bus_sel_cfg, bus_phase_strobe_n};
        c_next.cfg_s2 = c_reg.cfg_s1;
        c_next.dir_s1 = direction_n;
        c_next.dir_s2 = c_reg.dir_s1;
        c_next.req_s1 = h_reg.req_tgl;
        c_next.req_s2 = c_reg.req_s1;
        c_next.req_s3 = c_reg.req_s2;
        if (!c_reg.cfg_valid) begin
            c_next.cfg_cnt = c_reg.cfg_cnt + 2'h1;
            if (c_reg.cfg_cnt == `SSHP_CFG_SETTLE) begin // R12
                c_next.cfg_val = c_reg.cfg_s2;
                c_next.cfg_valid = 1'b1;
            end
        end
        if (c_reg.pending && !c_reg.refresh_hold) begin // R7
            c_next.pending = 1'b0;
            c_next.ack_tgl = ~c_reg.ack_tgl;
            c_next.rdata = big_end ? swap16(cur) : cur; // R13
            mem_we = h_reg.wr_op;
            c_next.acc_cnt = c_reg.acc_cnt + 16'h1;
            c_next.last_addr = h_reg.addr;
        end
        if (c_reg.req_s2 != c_reg.req_s3) begin
            c_next.pending = 1'b1;
        end
        if (apb_access && pwrite && paddr == `SSHP_OFF_CTRL) begin
            c_next.refresh_hold = pwdata[`SSHP_CTRL_HOLD_BIT];
        end
        if (apb_setup) begin
            c_next.prdata = 32'h0;
            unique case (paddr)
                `SSHP_OFF_CTRL: c_next.prdata[`SSHP_CTRL_HOLD_BIT] = c_reg.refresh_hold;
                `SSHP_OFF_STATUS: begin
                    c_next.prdata[`SSHP_ST_BIG_BIT] = big_end;
                    c_next.prdata[`SSHP_ST_SPLIT_BIT] = split_mode;
                    c_next.prdata[`SSHP_ST_CFGOK_BIT] = c_reg.cfg_valid;
                    c_next.prdata[`SSHP_ST_PEND_BIT] = c_reg.pending;
                    c_next.prdata[`SSHP_ST_DIR_BIT] = c_reg.dir_s2;
                    c_next.prdata[`SSHP_ST_CFG_LSB +: 5] = c_reg.cfg_val;
                end
                `SSHP_OFF_COUNT: c_next.prdata[15:0] = c_reg.acc_cnt;
                `SSHP_OFF_LADDR: c_next.prdata[16:0] = c_reg.last_addr;
                default: c_next.prdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            c_reg <= '{refresh_hold: `SSHP_CTRL_RESET, default: '0};
        end else begin
            c_reg <= c_next;
        end
    end

    always_ff @(posedge pclk) begin
        if (mem_we) begin
            mem[mem_idx] <= mem_wdata;
        end
    end

    // ****************************************
    // apb slave
    // ****************************************
    assign apb_setup = psel && !penable;
    assign apb_access = psel && penable;
    assign addr_ok = reg_hit(paddr);
    assign pready = 1'b1;
    assign pslverr = apb_access && !addr_ok;
    assign prdata = c_reg.prdata;

    a_cfg_frozen: assert property (@(posedge pclk) disable iff (!presetn) // R12
        (c_reg.cfg_valid && $past(c_reg.cfg_valid)) |-> $stable(c_reg.cfg_val))
        else $error("strap values changed after capture");

    a_endian_select: assert property (@(posedge pclk) disable iff (!presetn) // R13
        (c_reg.pending && !c_reg.refresh_hold && !h_reg.wr_op) |=>
        c_reg.rdata == (big_end ? swap16(mem[$past(mem_idx)]) : mem[$past(mem_idx)]))
        else $error("read data byte order wrong");

    a_refresh_blocks: assert property (@(posedge pclk) disable iff (!presetn) // R7
        (c_reg.refresh_hold && $past(c_reg.refresh_hold)) |-> $stable(c_reg.ack_tgl))
        else $error("access granted during refresh contention");

    a_grant_on_request: assert property (@(posedge pclk) disable iff (!presetn) // R7
        $changed(c_reg.ack_tgl) |-> $past(c_reg.pending))
        else $error("grant without a pending request");

    a_count_per_grant: assert property (@(posedge pclk) disable iff (!presetn) // R6
        $changed(c_reg.ack_tgl) |-> c_reg.acc_cnt == $past(c_reg.acc_cnt) + 16'h1)
        else $error("access count out of step with grants");

endmodule

/* File: test/sshp_host_model.sv */
`timescale 1ns/1ps
module sshp_host_model (
    input wire logic host_bus_clock,
    input wire logic hold_off_n,
    input wire sshp_pkg::sshp_word_t host_data_out,
    input wire logic host_data_oe,
    output sshp_pkg::sshp_addr_t host_addr,
    output sshp_pkg::sshp_word_t host_data_in,
    output logic device_select_n,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic high_byte_enable_n
);
    import sshp_pkg::*;
    initial begin
        host_addr = '0;
        host_data_in = '0;
        device_select_n = 1'b1;
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        high_byte_enable_n = 1'b1;
    end
    // ****************************************
    // one host transfer, stretched by hold-off
    // ****************************************
    task automatic xfer(input logic wr, input sshp_addr_t a, input sshp_word_t d,
                        input logic hbe_n, output sshp_word_t q, output logic ok);
        int n;
        logic lo;
        @(posedge host_bus_clock);
        host_addr <= a;
        host_data_in <= wr ? d : ~d;
        high_byte_enable_n <= hbe_n;
        device_select_n <= 1'b0;
        write_strobe_n <= ~wr;
        read_strobe_n <= wr;
        n = 0;
        do begin
            @(posedge host_bus_clock);
            n++;
        end while (hold_off_n !== 1'b0 && n < 8);
        lo = (hold_off_n === 1'b0);
        while (hold_off_n !== 1'b1 && n < 4000) begin
            @(posedge host_bus_clock);
            n++;
        end
        q = host_data_out;
        ok = lo && (hold_off_n === 1'b1) && (host_data_oe === ~wr);
        device_select_n <= 1'b1;
        read_strobe_n <= 1'b1;
        write_strobe_n <= 1'b1;
        host_data_in <= ~host_data_in;
        host_addr <= ~a;
        repeat (4) @(posedge host_bus_clock);
        ok = ok && (host_data_oe === 1'b0);
    endtask
endmodule

/* File: test/tb.sv */
`timescale 1ns/1ps
module tb;
    import sshp_pkg::*;
    logic pclk, hclk, presetn, psel, penable, pwrite, pready, pslverr, e, ok;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic oe, cs_n, rd_n, wr_n, hbe_n, hold_off_n, endian_cfg, bps_n, dir_n;
    logic [2:0] bus_sel_cfg;
    sshp_addr_t haddr;
    sshp_word_t hdi, hdo, w;
    int num_errors = 0;
    int total_checks = 0;
    // ****************************************
    // clocks and instances
    // ****************************************
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    initial begin
        hclk = 1'b0;
        #3;
        forever #7.5 hclk = ~hclk;
    end
    sshp_host_port uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .core_clock_in(pclk), .host_bus_clock(hclk), .host_addr(haddr),
        .host_data_in(hdi), .host_data_out(hdo), .host_data_oe(oe), .device_select_n(cs_n),
        .read_strobe_n(rd_n), .write_strobe_n(wr_n), .high_byte_enable_n(hbe_n),
        .bus_phase_strobe_n(bps_n), .direction_n(dir_n), .endian_cfg(endian_cfg),
        .bus_sel_cfg(bus_sel_cfg), .hold_off_n(hold_off_n));
    sshp_host_model hm (.host_bus_clock(hclk), .hold_off_n(hold_off_n), .host_data_out(hdo),
        .host_data_oe(oe), .host_addr(haddr), .host_data_in(hdi), .device_select_n(cs_n),
        .read_strobe_n(rd_n), .write_strobe_n(wr_n), .high_byte_enable_n(hbe_n));
    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic do_reset(input logic en, input logic [2:0] bs, input logic bp);
        @(posedge pclk);
        presetn <= 1'b0;
        endian_cfg <= en;
        bus_sel_cfg <= bs;
        bps_n <= bp;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (20) @(posedge pclk);
    endtask
    task automatic finish_test();
        $display("num_errors=%0d total_checks=%0d", num_errors, total_checks);
        if (num_errors == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ****************************************
    // tests
    // ****************************************
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        bps_n = 1'b1;
        dir_n = 1'b1;
        endian_cfg = 1'b0;
        bus_sel_cfg = 3'h7;
        do_reset(1'b0, 3'h7, 1'b1);
        apb(1'b0, 12'h004, 32'h0);
        chk(q & 32'h1f17, 32'h0f16);
        hm.xfer(1'b1, 17'h00024, 16'ha5c3, 1'b0, w, ok);
        chk(ok, 1'b1);
        hm.xfer(1'b1, 17'h00024, 16'h7e18, 1'b1, w, ok);
        chk(ok, 1'b1);
        hm.xfer(1'b0, 17'h00024, 16'h0, 1'b0, w, ok);
        chk({ok, w}, {1'b1, 16'ha518});
        hm.xfer(1'b1, 17'h1fffe, 16'h1234, 1'b0, w, ok);
        chk(ok, 1'b1);
        apb(1'b0, 12'h008, 32'h0);
        chk(q, 32'h4);
        apb(1'b0, 12'h00c, 32'h0);
        chk(q, 32'h1fffe);
        apb(1'b1, 12'h000, 32'h1);
        fork
            hm.xfer(1'b0, 17'h1fffe, 16'h0, 1'b0, w, ok);
            begin
                repeat (40) @(posedge hclk);
                chk(hold_off_n, 1'b0);
                apb(1'b0, 12'h000, 32'h0);
                chk(q, 32'h1);
                apb(1'b1, 12'h000, 32'h0);
            end
        join
        chk({ok, w}, {1'b1, 16'h1234});
        apb(1'b0, 12'h020, 32'h0);
        chk(e, 1'b1);
        do_reset(1'b1, 3'h7, 1'b1);
        apb(1'b0, 12'h004, 32'h0);
        chk(q & 32'h1f17, 32'h1f17);
        hm.xfer(1'b1, 17'h00040, 16'hc0de, 1'b0, w, ok);
        chk(ok, 1'b1);
        hm.xfer(1'b0, 17'h00040, 16'h0, 1'b0, w, ok);
        chk({ok, w}, {1'b1, 16'hc0de});
        do_reset(1'b0, 3'h6, 1'b1);
        apb(1'b0, 12'h004, 32'h0);
        chk(q & 32'h2, 32'h0);
        hm.xfer(1'b0, 17'h00040, 16'h0, 1'b0, w, ok);
        chk({ok, hold_off_n}, 2'b01);
        do_reset(1'b0, 3'h7, 1'b0);
        apb(1'b0, 12'h004, 32'h0);
        chk(q & 32'h1f02, 32'h0e00);
        hm.xfer(1'b0, 17'h00040, 16'h0, 1'b0, w, ok);
        chk({ok, hold_off_n}, 2'b01);
        finish_test();
    end
    initial begin
        #1000000;
        num_errors++;
        finish_test();
    end
endmodule
